/* ltpg_defs.svh */
// Register indices, field positions, reset values and pattern codes of the pattern generator
`ifndef LTPG_DEFS_SVH
`define LTPG_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LTPG_IDX_START_HI 6'h30
`define LTPG_IDX_START_LO 6'h31
`define LTPG_IDX_WIDTH_HI 6'h32
`define LTPG_IDX_WIDTH_LO 6'h33
`define LTPG_IDX_CTRL 6'h34
`define LTPG_IDX_STATUS 6'h3c

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define LTPG_CTRL_PAT_EN 7
`define LTPG_CTRL_MODE_HI 6
`define LTPG_CTRL_MODE_LO 4
`define LTPG_CTRL_PRBS_EN 3
`define LTPG_CTRL_SEED_EN 2
`define LTPG_CTRL_CHSEL_HI 1
`define LTPG_CTRL_CHSEL_LO 0
`define LTPG_CHSEL_BOTH 2'h0
`define LTPG_CHSEL_CH1 2'h1
`define LTPG_CHSEL_CH2 2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LTPG_RST_BYTE 8'h00
`define LTPG_RST_CTRL 8'h00
`define LTPG_RST_DATA 14'h0000

// ----------------------------------------------------------------
// Pattern codes
// ----------------------------------------------------------------
`define LTPG_IDLE_CODE 14'h0000
`define LTPG_FIXED_CODE 14'h2000
`define LTPG_HI_CODE 14'h3fff
`define LTPG_LO_CODE 14'h0100
`define LTPG_LINK_A 14'h2aaa
`define LTPG_LINK_B 14'h1555
`define LTPG_SEED 14'h0001
`define LTPG_PRSR_TAPS 14'h3802
`define LTPG_PITCH_BIT 3
`define LTPG_CNT_MAX 16'hffff

`endif

/* ltpg_pkg.sv */
// Types shared by the pattern generator files
package ltpg_pkg;

  // ----------------------------------------------------------------
  // Pattern modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LTPG_MODE_FIXED = 3'h0,
    LTPG_MODE_HGRAD = 3'h1,
    LTPG_MODE_VGRAD = 3'h2,
    LTPG_MODE_LATTICE = 3'h3,
    LTPG_MODE_STRIPE = 3'h4,
    LTPG_MODE_LINK_SYNC = 3'h5,
    LTPG_MODE_LINK_FREE = 3'h6,
    LTPG_MODE_UNUSED = 3'h7
  } ltpg_mode_t;

  typedef logic [13:0] ltpg_data_t;

endpackage

/* ltpg_prsr.sv */
// Pseudo-random shift register with seed load
`timescale 1ns/100ps
`default_nettype none
module ltpg_prsr #(
  parameter int WIDTH = 14,
  parameter logic [WIDTH-1:0] TAPS = 14'h3802
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic load,
  input wire logic [WIDTH-1:0] seed,
  output logic [WIDTH-1:0] state
);

  logic fb;

  assign fb = ^(state & TAPS);

  // Reset to one so the register never sits in the all-zero lockup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= {{(WIDTH-1){1'b0}}, 1'b1};
    end else if (en) begin
      if (load) begin
        state <= seed;
      end else begin
        state <= {state[WIDTH-2:0], fb};
      end
    end
  end

endmodule
`default_nettype wire

/* ltpg_top.sv */
// Test pattern generator for the serialized pixel outputs, with APB register access
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "ltpg_defs.svh"

// Notes on behaviour
// R01: Software loads baseline values after power-up
// R02: Region start built from high, low bytes
// R03: Region width built from high, low bytes
// R04: Control bit 7 swaps conversion data for patterns
// R05: Mode bits pick fixed, gradients, lattice, stripe
// R06: Link test synchronous or free-running; 111 unused
// R07: Control resets to zero, normal data flows
// R08: Start and width bytes reset to zero
// R09: Pseudo-random enable overrides pattern switch
// R10: Seed loads at line-start leading edge
// R11: Channel select bits route pattern per channel
// R12: Pixel count restarts at each line start
// R13: Idle code outside valid region; link free mode sends link words there too
module ltpg_top #(
  parameter logic [13:0] SEED = `LTPG_SEED,
  parameter logic [13:0] FIXED_CODE = `LTPG_FIXED_CODE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_start_pulse,
  input wire logic [13:0] conv_ch1_data,
  input wire logic [13:0] conv_ch2_data,
  output logic [13:0] lvds_ch1_data,
  output logic [13:0] lvds_ch2_data
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] start_hi_r, start_lo_r, width_hi_r, width_lo_r, ctrl_r;
  logic [15:0] start_val, width_val;
  logic [15:0] pix_cnt_r, line_cnt_r, rel_pix;
  logic sync1_r, sync2_r, sync3_r, line_edge;
  logic setup, access_done, wr_en, mapped;
  logic [5:0] idx;
  logic [31:0] rd_nxt;
  logic in_region, src_en, ch1_sel, ch2_sel;
  logic link_sync_r, link_free_r;
  logic [13:0] prsr_state, pat_nxt, hrel;
  ltpg_pkg::ltpg_mode_t mode;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign idx = paddr[7:2];
  assign setup = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_en = access_done & pwrite & mapped & clk_en;
  assign mapped = (paddr[1:0] == 2'h0) &&
                  ((idx == `LTPG_IDX_START_HI) || (idx == `LTPG_IDX_START_LO) ||
                   (idx == `LTPG_IDX_WIDTH_HI) || (idx == `LTPG_IDX_WIDTH_LO) ||
                   (idx == `LTPG_IDX_CTRL) || (idx == `LTPG_IDX_STATUS));

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (mapped) begin
      unique case (idx)
        `LTPG_IDX_START_HI: rd_nxt = {24'h00_0000, start_hi_r};
        `LTPG_IDX_START_LO: rd_nxt = {24'h00_0000, start_lo_r};
        `LTPG_IDX_WIDTH_HI: rd_nxt = {24'h00_0000, width_hi_r};
        `LTPG_IDX_WIDTH_LO: rd_nxt = {24'h00_0000, width_lo_r};
        `LTPG_IDX_CTRL: rd_nxt = {24'h00_0000, ctrl_r};
        default: rd_nxt = {15'h0000, in_region, pix_cnt_r};
      endcase
    end
  end

  // One wait-free access cycle: ready rises in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en && setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr <= ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_hi_r <= `LTPG_RST_BYTE; // R08
      start_lo_r <= `LTPG_RST_BYTE; // R08
    end else if (wr_en && idx == `LTPG_IDX_START_HI) begin
      start_hi_r <= pwdata[7:0]; // R02
    end else if (wr_en && idx == `LTPG_IDX_START_LO) begin
      start_lo_r <= pwdata[7:0]; // R02
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_hi_r <= `LTPG_RST_BYTE; // R08
      width_lo_r <= `LTPG_RST_BYTE; // R08
    end else if (wr_en && idx == `LTPG_IDX_WIDTH_HI) begin
      width_hi_r <= pwdata[7:0]; // R03
    end else if (wr_en && idx == `LTPG_IDX_WIDTH_LO) begin
      width_lo_r <= pwdata[7:0]; // R03
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `LTPG_RST_CTRL; // R07
    end else if (wr_en && idx == `LTPG_IDX_CTRL) begin
      ctrl_r <= pwdata[7:0];
    end
  end

  assign start_val = {start_hi_r, start_lo_r}; // R02
  assign width_val = {width_hi_r, width_lo_r}; // R03
  assign mode = ltpg_pkg::ltpg_mode_t'(ctrl_r[`LTPG_CTRL_MODE_HI:`LTPG_CTRL_MODE_LO]);

  // ----------------------------------------------------------------
  // Line-start synchroniser and counters
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else if (clk_en) begin
      sync1_r <= line_start_pulse;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign line_edge = sync2_r & ~sync3_r;

  // Saturates so a missing line start cannot wrap back into the region
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_cnt_r <= 16'h0000;
    end else if (clk_en) begin
      if (line_edge) begin
        pix_cnt_r <= 16'h0000; // R12
      end else if (pix_cnt_r != `LTPG_CNT_MAX) begin
        pix_cnt_r <= pix_cnt_r + 16'h0001; // R12
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_cnt_r <= 16'h0000;
    end else if (clk_en && line_edge) begin
      line_cnt_r <= line_cnt_r + 16'h0001;
    end
  end

  assign rel_pix = pix_cnt_r - start_val;
  assign hrel = rel_pix[13:0];
  assign in_region = (pix_cnt_r >= start_val) && (rel_pix < width_val); // R02 R03

  // ----------------------------------------------------------------
  // Link test toggles and pseudo-random source
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_sync_r <= 1'b0;
      link_free_r <= 1'b0;
    end else if (clk_en) begin
      link_sync_r <= line_edge ? 1'b0 : ~link_sync_r; // R06
      link_free_r <= ~link_free_r; // R06
    end
  end

  ltpg_prsr #(
    .WIDTH(14),
    .TAPS(`LTPG_PRSR_TAPS)
  ) u_prsr (
    .clk(pclk),
    .rst_n(presetn),
    .en(clk_en),
    .load(line_edge & ctrl_r[`LTPG_CTRL_SEED_EN]), // R10
    .seed(SEED),
    .state(prsr_state)
  );

  // ----------------------------------------------------------------
  // Pattern selection
  // ----------------------------------------------------------------
  always_comb begin
    pat_nxt = `LTPG_IDLE_CODE; // R13
    if (ctrl_r[`LTPG_CTRL_PRBS_EN]) begin
      if (in_region) begin
        pat_nxt = prsr_state; // R09
      end
    end else if (mode == ltpg_pkg::LTPG_MODE_LINK_FREE) begin
      pat_nxt = link_free_r ? `LTPG_LINK_A : `LTPG_LINK_B; // R06
    end else if (in_region) begin
      unique case (mode)
        ltpg_pkg::LTPG_MODE_FIXED: pat_nxt = FIXED_CODE; // R05
        ltpg_pkg::LTPG_MODE_HGRAD: pat_nxt = hrel; // R05
        ltpg_pkg::LTPG_MODE_VGRAD: pat_nxt = line_cnt_r[13:0]; // R05
        ltpg_pkg::LTPG_MODE_LATTICE: begin
          pat_nxt = (hrel[`LTPG_PITCH_BIT] ^ line_cnt_r[`LTPG_PITCH_BIT]) ?
                    `LTPG_HI_CODE : `LTPG_LO_CODE; // R05
        end
        ltpg_pkg::LTPG_MODE_STRIPE: begin
          pat_nxt = hrel[`LTPG_PITCH_BIT] ? `LTPG_HI_CODE : `LTPG_LO_CODE; // R05
        end
        ltpg_pkg::LTPG_MODE_LINK_SYNC: begin
          pat_nxt = link_sync_r ? `LTPG_LINK_A : `LTPG_LINK_B; // R06
        end
        ltpg_pkg::LTPG_MODE_LINK_FREE: pat_nxt = `LTPG_IDLE_CODE;
        ltpg_pkg::LTPG_MODE_UNUSED: pat_nxt = `LTPG_IDLE_CODE; // R06
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output source and channel routing
  // ----------------------------------------------------------------
  assign src_en = ctrl_r[`LTPG_CTRL_PAT_EN] | ctrl_r[`LTPG_CTRL_PRBS_EN]; // R04 R09
  assign ch1_sel = (ctrl_r[1:0] == `LTPG_CHSEL_BOTH) || (ctrl_r[1:0] == `LTPG_CHSEL_CH1); // R11
  assign ch2_sel = (ctrl_r[1:0] == `LTPG_CHSEL_BOTH) || (ctrl_r[1:0] == `LTPG_CHSEL_CH2); // R11

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvds_ch1_data <= `LTPG_RST_DATA;
      lvds_ch2_data <= `LTPG_RST_DATA;
    end else if (clk_en) begin
      lvds_ch1_data <= (src_en && ch1_sel) ? pat_nxt : conv_ch1_data; // R04 R11
      lvds_ch2_data <= (src_en && ch2_sel) ? pat_nxt : conv_ch2_data; // R04 R11
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_START_HI_WR: assert property (@(posedge pclk) disable iff (!presetn) // R02
    (wr_en && idx == `LTPG_IDX_START_HI) |=> (start_val[15:8] == $past(pwdata[7:0])))
    else $error("Start high byte not stored");

  AST_WIDTH_LO_WR: assert property (@(posedge pclk) disable iff (!presetn) // R03
    (wr_en && idx == `LTPG_IDX_WIDTH_LO) |=> (width_val[7:0] == $past(pwdata[7:0])))
    else $error("Width low byte not stored");

  AST_NORMAL_PASS: assert property (@(posedge pclk) disable iff (!presetn) // R04
    (clk_en && !src_en) |=> (lvds_ch1_data == $past(conv_ch1_data)) &&
    (lvds_ch2_data == $past(conv_ch2_data)))
    else $error("Conversion data not passed while patterns off");

  AST_HGRAD: assert property (@(posedge pclk) disable iff (!presetn) // R05
    (clk_en && src_en && !ctrl_r[3] && ch1_sel && in_region &&
     mode == ltpg_pkg::LTPG_MODE_HGRAD) |=> (lvds_ch1_data == $past(hrel)))
    else $error("Horizontal gradient value wrong");

  AST_LINK_ALIGN: assert property (@(posedge pclk) disable iff (!presetn) // R06
    (clk_en && line_edge) |=> !link_sync_r)
    else $error("Link test phase not aligned to line start");

  AST_BASELINE: assert property (@(posedge pclk) disable iff (!presetn) // R07
    !$past(presetn) |-> (ctrl_r == `LTPG_RST_CTRL) && (lvds_ch1_data == `LTPG_RST_DATA))
    else $error("Control not at baseline after reset");

  AST_BYTES_BASELINE: assert property (@(posedge pclk) disable iff (!presetn) // R08
    !$past(presetn) |-> (start_val == 16'h0000) && (width_val == 16'h0000))
    else $error("Region bytes not at baseline after reset");

  AST_PRBS_WINS: assert property (@(posedge pclk) disable iff (!presetn) // R09
    (clk_en && ctrl_r[3] && ch1_sel && in_region) |=> (lvds_ch1_data == $past(prsr_state)))
    else $error("Pseudo-random data not selected");

  AST_SEED_LOAD: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (clk_en && line_edge && ctrl_r[2]) |=> (prsr_state == SEED))
    else $error("Seed not loaded at line start");

  AST_CH_SEL: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (clk_en && ctrl_r[1:0] == `LTPG_CHSEL_CH1) |=> (lvds_ch2_data == $past(conv_ch2_data)))
    else $error("Channel two not left on conversion data");

  AST_PIX_RESTART: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (clk_en && line_edge) |=> (pix_cnt_r == 16'h0000))
    else $error("Pixel count not restarted");

  AST_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (clk_en && src_en && ch1_sel && !in_region &&
     mode != ltpg_pkg::LTPG_MODE_LINK_FREE) |=> (lvds_ch1_data == `LTPG_IDLE_CODE))
    else $error("Idle code missing outside region");

endmodule
`default_nettype wire

/* ltpg_line_model.sv */
// Far-side model: line timing source for the pixel stream
`timescale 1ns/100ps
`default_nettype none
module ltpg_line_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  output logic line_start_pulse
);
  logic [1:0] hold_r;
  // ----------------------------------------------------------------
  // Line pulse
  // ----------------------------------------------------------------
  // Held high three cycles so the receiving sync stage sees a clean level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 2'h0;
      line_start_pulse <= 1'b0;
    end else if (go && hold_r == 2'h0 && !line_start_pulse) begin
      hold_r <= 2'h3;
      line_start_pulse <= 1'b1;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
      line_start_pulse <= (hold_r != 2'h1);
    end
  end
endmodule
`default_nettype wire

/* tb_afe_lvds_test_pattern_generator.sv */
// Self-checking bench for the pattern generator: APB registers and pixel stream
`timescale 1ns/100ps
`default_nettype none
`include "ltpg_defs.svh"
module tb_afe_lvds_test_pattern_generator;
  typedef struct {logic [31:0] data; logic rd; logic err;} ltpg_apb_exp_t;
  typedef struct {int cyc; logic [1:0] k1; logic [1:0] k2; logic [13:0] v1; logic [13:0] v2;} ltpg_pix_exp_t;
  logic pclk, presetn, clk_en, psel, penable, pwrite, go, line_start_pulse, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [13:0] conv1, conv2, lvds1, lvds2;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  ltpg_apb_exp_t aq[$];
  ltpg_pix_exp_t pq[$];
  ltpg_apb_exp_t ae;
  ltpg_pix_exp_t pe;
  logic [7:0] tc [14] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h91, 8'ha2, 8'hb3, 8'hc0,
                          8'hd0, 8'he1, 8'hf0, 8'h0c, 8'hb0};
  logic [15:0] ts [14] = '{16'h0003, 16'h0003, 16'h0005, 16'h0103, 16'h0002, 16'h0003,
                           16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h0003,
                           16'h0004, 16'h0000};
  logic [15:0] tw [14] = '{16'h0004, 16'h0004, 16'h0000, 16'h0004, 16'h0100, 16'h0006,
                           16'h0006, 16'h0006, 16'h0006, 16'h0005, 16'h0006, 16'h0006,
                           16'h0005, 16'h0010};

  ltpg_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_start_pulse(line_start_pulse),
    .conv_ch1_data(conv1), .conv_ch2_data(conv2), .lvds_ch1_data(lvds1),
    .lvds_ch2_data(lvds2));
  ltpg_line_model i_far (.pclk(pclk), .presetn(presetn), .go(go),
    .line_start_pulse(line_start_pulse));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Kind 0 exact, 1 content not modelled, 2 either link word
  task automatic cmp_pix(input string name, input logic [13:0] seen, input logic [1:0] k,
                         input logic [13:0] v);
    if (k == 2'h0) chk(name, {18'h0, seen}, {18'h0, v});
    else if (k == 2'h2) chk(name, {31'h0, seen === `LTPG_LINK_A || seen === `LTPG_LINK_B}, 32'h1);
  endtask

  function automatic void pix_exp(input logic [7:0] c, input logic [15:0] s, input logic [15:0] w,
      input int n, input int ch, input int ln, input logic [13:0] conv, output logic [1:0] k,
      output logic [13:0] v);
    logic inr;
    logic on;
    logic [13:0] rel;
    logic [13:0] lin;
    logic [13:0] st;
    inr = (n >= int'(s)) && (n < int'(s) + int'(w));
    on = (c[7] || c[3]) && (c[1:0] == 2'h0 || int'(c[1:0]) == ch);
    rel = 14'(n - int'(s));
    lin = 14'(ln);
    // Seed sits in the shift register at pixel 0, one shift per pixel after
    st = `LTPG_SEED;
    for (int j = 0; j < n; j++) st = {st[12:0], ^(st & `LTPG_PRSR_TAPS)};
    k = 2'h0;
    v = `LTPG_IDLE_CODE;
    if (!on) v = conv;
    else if (c[3]) begin
      if (inr) v = st;
      if (inr && !c[2]) k = 2'h1;
    end else if (c[6:4] == 3'h6) k = 2'h2;
    else if (inr) begin
      case (c[6:4])
        3'h0: v = `LTPG_FIXED_CODE;
        3'h1: v = rel;
        3'h2: v = lin;
        3'h3: v = (rel[`LTPG_PITCH_BIT] ^ lin[`LTPG_PITCH_BIT]) ?
                  `LTPG_HI_CODE : `LTPG_LO_CODE;
        3'h4: v = rel[`LTPG_PITCH_BIT] ? `LTPG_HI_CODE : `LTPG_LO_CODE;
        3'h5: v = (n % 2) ? `LTPG_LINK_A : `LTPG_LINK_B;
        default: v = `LTPG_IDLE_CODE;
      endcase
    end
  endfunction

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (psel && penable && pready && aq.size() > 0) begin
      ae = aq.pop_front();
      chk("pslverr", {31'h0, pslverr}, {31'h0, ae.err});
      if (ae.rd) chk("prdata", prdata, ae.data);
    end
    if (pq.size() > 0 && pq[0].cyc == cyc) begin
      pe = pq.pop_front();
      cmp_pix("lvds_ch1_data", lvds1, pe.k1, pe.v1);
      cmp_pix("lvds_ch2_data", lvds2, pe.k2, pe.v2);
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                     input logic [31:0] ed, input logic ee);
    ltpg_apb_exp_t e;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= ($urandom() & 32'hffffff00) | {24'h0, wd};
    e.data = ed;
    e.rd = !wr;
    e.err = ee;
    aq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_line(input logic [7:0] c, input logic [15:0] s, input logic [15:0] w,
                          input int ln);
    ltpg_pix_exp_t e;
    int c0;
    apb(1'b1, 8'hc0, s[15:8], 32'h0, 1'b0);
    apb(1'b1, 8'hc4, s[7:0], 32'h0, 1'b0);
    apb(1'b1, 8'hc8, w[15:8], 32'h0, 1'b0);
    apb(1'b1, 8'hcc, w[7:0], 32'h0, 1'b0);
    apb(1'b1, 8'hd0, c, 32'h0, 1'b0);
    apb(1'b0, 8'hc0, 8'h00, {24'h0, s[15:8]}, 1'b0);
    apb(1'b0, 8'hd0, 8'h00, {24'h0, c}, 1'b0);
    conv1 <= 14'($urandom());
    conv2 <= 14'($urandom());
    @(posedge pclk);
    go <= 1'b1;
    c0 = cyc;
    for (int n = 0; n < 16; n++) begin
      e.cyc = c0 + 6 + n;
      pix_exp(c, s, w, n, 1, ln, conv1, e.k1, e.v1);
      pix_exp(c, s, w, n, 2, ln, conv2, e.k2, e.v2);
      pq.push_back(e);
    end
    @(posedge pclk);
    go <= 1'b0;
    repeat (40) if (pq.size() > 0) @(posedge pclk);
    $display("Test ctrl %h start %h width %h done", c, s, w);
  endtask

  // Outputs must hold while the clock enable is low, then follow again
  task automatic hold_test;
    ltpg_pix_exp_t e;
    apb(1'b1, 8'hd0, 8'h00, 32'h0, 1'b0);
    @(posedge pclk);
    e.k1 = 2'h0;
    e.k2 = 2'h0;
    e.v1 = conv1;
    e.v2 = conv2;
    for (int n = 1; n < 5; n++) begin
      e.cyc = cyc + n;
      pq.push_back(e);
    end
    e.v1 = ~conv1;
    e.v2 = ~conv2;
    e.cyc = cyc + 5;
    pq.push_back(e);
    clk_en <= 1'b0;
    conv1 <= ~conv1;
    conv2 <= ~conv2;
    repeat (3) @(posedge pclk);
    clk_en <= 1'b1;
    repeat (4) @(posedge pclk);
    $display("Test clock enable hold done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #300000;
    err_count++;
    test_done();
  end

  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    go = 1'b0;
    conv1 = 14'h0000;
    conv2 = 14'h0000;
    void'($urandom(12455));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 8'hc0; a <= 8'hd0; a += 4) apb(1'b0, 8'(a), 8'h00, 32'h0, 1'b0);
    apb(1'b0, 8'h00, 8'h00, 32'h0, 1'b1);
    apb(1'b0, 8'hc1, 8'h00, 32'h0, 1'b1);
    apb(1'b1, 8'h04, 8'h5a, 32'h0, 1'b1);
    apb(1'b1, 8'hf0, 8'h5a, 32'h0, 1'b0);
    // Baseline load after power-up, as software must do
    for (int a = 8'hc0; a <= 8'hd0; a += 4) apb(1'b1, 8'(a), 8'h00, 32'h0, 1'b0);
    $display("Test reset and decode done");
    for (int i = 0; i < 14; i++) run_line(tc[i], ts[i], tw[i], i + 1);
    hold_test();
    chk("queues", 32'(aq.size() + pq.size()), 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
